// ### tcv_pkg.sv
// Function
// - Mode 0: pin follows stored level bit
// - Modes 1,4,5: set, toggle, reset on equal
// - Modes 2,3,6,7: channel then period actions
// - Output changes on timer clock edge; mode 0 on level write
// - Control bit 8 selects compare or snapshot
// - Latch load: immediate, or at zero
// - Select 2: period or zero, mode dependent
// - Select 3: load when counter equals latch
// - Bit 11 picks direct or synchronised input
// - Bits 12-13 pick A, B, ground, high
// - Channel 0 flag has own top-priority request
// - Other flags and overflow share one request
// - Vector: even code of highest pending source
// - Vector read clears only highest pending flag
// - Vector write also clears highest pending flag
// - Flag sets on snapshot or equal, enable regardless
// - Overrun on unread second snapshot, software clears
// - Channel request needs flag and enable, software settable
`default_nettype none
package tcv_pkg;
	localparam int          NCH           = 7;
	localparam int          NSH           = 7;
	localparam logic [15:0] ADDR_CTL_BASE = 16'h0182;
	localparam logic [15:0] ADDR_VAL_BASE = 16'h0192;
	localparam logic [15:0] ADDR_VECTOR   = 16'h011E;
	localparam logic [15:0] ADDR_STEP     = 16'h0002;
	localparam logic [15:0] CTL_RESET     = 16'h0000;
	localparam logic [15:0] CTL_WR_MASK   = 16'hFFF7;
	localparam logic [15:0] VEC_NONE      = 16'h0000;
	localparam logic [15:0] VEC_OVERFLOW  = 16'h000E;
	localparam int          B_FLAG        = 0;
	localparam int          B_OVR         = 1;
	localparam int          B_LVL         = 2;
	localparam int          B_IN          = 3;
	localparam int          B_IE          = 4;
	localparam int          B_MODE        = 5;
	localparam int          B_CAP         = 8;
	localparam int          B_LATCH_LOAD_SELECT        = 9;
	localparam int          B_SCS         = 11;
	localparam int          B_ISEL        = 12;
	localparam int          B_EDGE        = 14;

	typedef enum logic [2:0] {
		OM_LEVEL   = 3'h0,
		OM_SET     = 3'h1,
		OM_TGL_RST = 3'h2,
		OM_SET_RST = 3'h3,
		OM_TOGGLE  = 3'h4,
		OM_RESET   = 3'h5,
		OM_TGL_SET = 3'h6,
		OM_RST_SET = 3'h7
	} tcv_outmode_t;

	typedef enum logic [1:0] {
		LD_NOW    = 2'h0,
		LD_ZERO   = 2'h1,
		LD_PERIOD = 2'h2,
		LD_MATCH  = 2'h3
	} tcv_load_t;

	typedef enum logic [1:0] {
		IS_A   = 2'h0,
		IS_B   = 2'h1,
		IS_GND = 2'h2,
		IS_VCC = 2'h3
	} tcv_insel_t;

	typedef enum logic [1:0] {
		ED_NONE = 2'h0,
		ED_RISE = 2'h1,
		ED_FALL = 2'h2,
		ED_BOTH = 2'h3
	} tcv_edge_t;
endpackage : tcv_pkg
`default_nettype wire

// ### tcv_vec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcv_vec_if;
	logic [tcv_pkg::NSH-1:0] pend;
	logic [tcv_pkg::NSH-1:0] top;
	logic [15:0]             code;
	modport src (output pend, input top, input code);
	modport enc (input pend, output top, output code);
endinterface : tcv_vec_if
`default_nettype wire

// ### tcv_vector_enc.sv
`timescale 1ns/1ps
`default_nettype none
module tcv_vector_enc (
	tcv_vec_if.enc vif
);
	// Lowest index wins: channel 1 first, overflow last
	always_comb begin
		vif.top  = '0;
		vif.code = tcv_pkg::VEC_NONE;
		for (int i = tcv_pkg::NSH - 1; i >= 0; i--) begin
			if (vif.pend[i]) begin
				vif.top    = '0;
				vif.top[i] = 1'b1;
				vif.code   = 16'(2 * (i + 1));
			end
		end
	end
endmodule : tcv_vector_enc
`default_nettype wire

// ### tcv_channel_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tcv_channel_ctrl (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic [15:0]             bus_addr,
	input  wire logic [15:0]             bus_wdata,
	input  wire logic                    bus_wr,
	input  wire logic                    bus_rd,
	output logic      [15:0]             bus_rdata,
	input  wire logic [15:0]             counter_value,
	input  wire logic                    count_step,
	input  wire logic                    count_updown,
	input  wire logic                    counter_wrap,
	input  wire logic                    ch0_irq_accept,
	input  wire logic [tcv_pkg::NCH-1:0] snapshot_input_a,
	input  wire logic [tcv_pkg::NCH-1:0] snapshot_input_b,
	output logic      [tcv_pkg::NCH-1:0] out_pin,
	output logic      [15:0]             period_latch,
	output logic                         irq_ch0,
	output logic                         irq_shared
);
	typedef struct packed {
		logic [tcv_pkg::NCH-1:0][15:0] ctl;
		logic [tcv_pkg::NCH-1:0][15:0] ccr;
		logic [tcv_pkg::NCH-1:0][15:0] latch;
		logic [tcv_pkg::NCH-1:0]       outq;
		logic [tcv_pkg::NCH-1:0]       a_meta;
		logic [tcv_pkg::NCH-1:0]       a_sync;
		logic [tcv_pkg::NCH-1:0]       b_meta;
		logic [tcv_pkg::NCH-1:0]       b_sync;
		logic [tcv_pkg::NCH-1:0]       sel_stage;
		logic [tcv_pkg::NCH-1:0]       sel_prev;
		logic [tcv_pkg::NCH-1:0]       unread;
		logic                          ovf_flag;
		logic [15:0]                   rdata;
	} tcv_state_t;

	tcv_state_t state_reg;
	tcv_state_t state_next;
	tcv_vec_if  vif ();

	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] base, input int i);
		addr_hit = (a == base + tcv_pkg::ADDR_STEP * 16'(i));
	endfunction : addr_hit

	tcv_vector_enc u_vec (
		.vif (vif)
	);

	genvar g;
	generate
		for (g = 1; g < tcv_pkg::NCH; g++) begin : g_pend
			assign vif.pend[g-1] = state_reg.ctl[g][tcv_pkg::B_FLAG];
		end
	endgenerate
	assign vif.pend[tcv_pkg::NSH-1] = state_reg.ovf_flag;

	logic [tcv_pkg::NCH-1:0] shared_req;
	always_comb begin
		shared_req = '0;
		for (int i = 1; i < tcv_pkg::NCH; i++) begin
			shared_req[i] = state_reg.ctl[i][tcv_pkg::B_FLAG] & state_reg.ctl[i][tcv_pkg::B_IE];
		end
	end

	// Overflow enable lives in the counter control word; the flag is passed in already qualified
	assign irq_ch0      = state_reg.ctl[0][tcv_pkg::B_FLAG] & state_reg.ctl[0][tcv_pkg::B_IE];
	assign irq_shared   = (|shared_req) | state_reg.ovf_flag;
	assign out_pin      = state_reg.outq;
	assign period_latch = state_reg.latch[0];
	assign bus_rdata    = state_reg.rdata;

	always_comb begin
		logic                  vec_access;
		logic                  cur;
		logic                  now;
		logic                  edge_hit;
		logic                  eq_ev;
		logic                  per_ev;
		logic                  snap;
		logic                  load_ev;
		logic                  ctl_wr;
		logic                  ccr_wr;
		tcv_pkg::tcv_outmode_t om;
		state_next = state_reg;
		vec_access = (bus_rd | bus_wr) && bus_addr == tcv_pkg::ADDR_VECTOR;
		cur        = 1'b0;
		now        = 1'b0;
		edge_hit   = 1'b0;
		eq_ev      = 1'b0;
		per_ev     = 1'b0;
		snap       = 1'b0;
		load_ev    = 1'b0;
		ctl_wr     = 1'b0;
		ccr_wr     = 1'b0;
		om         = tcv_pkg::OM_LEVEL;

		state_next.a_meta = snapshot_input_a;
		state_next.a_sync = state_reg.a_meta;
		state_next.b_meta = snapshot_input_b;
		state_next.b_sync = state_reg.b_meta;

		if (bus_rd) begin
			state_next.rdata = 16'h0000;
			if (bus_addr == tcv_pkg::ADDR_VECTOR)
				state_next.rdata = vif.code;
			for (int i = 0; i < tcv_pkg::NCH; i++) begin
				if (addr_hit(bus_addr, tcv_pkg::ADDR_CTL_BASE, i))
					state_next.rdata = state_reg.ctl[i];
				if (addr_hit(bus_addr, tcv_pkg::ADDR_VAL_BASE, i))
					state_next.rdata = state_reg.ccr[i];
			end
		end

		for (int i = 0; i < tcv_pkg::NCH; i++) begin
			unique case (tcv_pkg::tcv_insel_t'(state_reg.ctl[i][tcv_pkg::B_ISEL +: 2]))
				tcv_pkg::IS_A:   cur = state_reg.a_sync[i];
				tcv_pkg::IS_B:   cur = state_reg.b_sync[i];
				tcv_pkg::IS_GND: cur = 1'b0;
				tcv_pkg::IS_VCC: cur = 1'b1;
			endcase
			// Direct path still has the pin synchronisers; the clocked path adds one timer stage
			state_next.sel_stage[i] = cur;
			now = state_reg.ctl[i][tcv_pkg::B_SCS] ? state_reg.sel_stage[i] : cur;
			state_next.sel_prev[i] = now;
			unique case (tcv_pkg::tcv_edge_t'(state_reg.ctl[i][tcv_pkg::B_EDGE +: 2]))
				tcv_pkg::ED_NONE: edge_hit = 1'b0;
				tcv_pkg::ED_RISE: edge_hit = now & ~state_reg.sel_prev[i];
				tcv_pkg::ED_FALL: edge_hit = ~now & state_reg.sel_prev[i];
				tcv_pkg::ED_BOTH: edge_hit = now ^ state_reg.sel_prev[i];
			endcase

			eq_ev  = count_step && counter_value == state_reg.latch[i];
			per_ev = count_step && counter_value == state_reg.latch[0];
			// Mode switch is not guarded against a coincident edge; software orders the two
			snap   = state_reg.ctl[i][tcv_pkg::B_CAP] & edge_hit;
			ctl_wr = bus_wr && addr_hit(bus_addr, tcv_pkg::ADDR_CTL_BASE, i);
			ccr_wr = bus_wr && addr_hit(bus_addr, tcv_pkg::ADDR_VAL_BASE, i);

			if (ctl_wr)
				state_next.ctl[i] = (bus_wdata & tcv_pkg::CTL_WR_MASK)
					| (state_reg.ctl[i] & ~tcv_pkg::CTL_WR_MASK);
			state_next.ctl[i][tcv_pkg::B_IN] = now;
			if (i == 0 && ch0_irq_accept)
				state_next.ctl[i][tcv_pkg::B_FLAG] = 1'b0;
			if (i > 0 && vec_access && vif.top[i-1])
				state_next.ctl[i][tcv_pkg::B_FLAG] = 1'b0;
			// Hardware set beats any clear in the same cycle
			if (state_reg.ctl[i][tcv_pkg::B_CAP] ? snap : eq_ev)
				state_next.ctl[i][tcv_pkg::B_FLAG] = 1'b1;
			if (snap && state_reg.unread[i])
				state_next.ctl[i][tcv_pkg::B_OVR] = 1'b1;

			if (bus_rd && addr_hit(bus_addr, tcv_pkg::ADDR_VAL_BASE, i))
				state_next.unread[i] = 1'b0;
			if (ccr_wr)
				state_next.ccr[i] = bus_wdata;
			if (snap) begin
				state_next.ccr[i]    = counter_value;
				state_next.unread[i] = 1'b1;
			end

			unique case (tcv_pkg::tcv_load_t'(state_reg.ctl[i][tcv_pkg::B_LATCH_LOAD_SELECT +: 2]))
				tcv_pkg::LD_NOW:    load_ev = 1'b0;
				tcv_pkg::LD_ZERO:   load_ev = count_step && counter_value == 16'h0000;
				tcv_pkg::LD_PERIOD: load_ev = count_step && (counter_value == 16'h0000
					|| (count_updown && counter_value == state_reg.latch[0]));
				tcv_pkg::LD_MATCH:  load_ev = eq_ev;
			endcase
			if (ccr_wr && state_reg.ctl[i][tcv_pkg::B_LATCH_LOAD_SELECT +: 2] == 2'(tcv_pkg::LD_NOW))
				state_next.latch[i] = bus_wdata;
			else if (load_ev)
				state_next.latch[i] = state_reg.ccr[i];

			om = tcv_pkg::tcv_outmode_t'(state_reg.ctl[i][tcv_pkg::B_MODE +: 3]);
			unique case (om)
				tcv_pkg::OM_LEVEL:
					state_next.outq[i] = state_reg.ctl[i][tcv_pkg::B_LVL];
				tcv_pkg::OM_SET:
					if (eq_ev) state_next.outq[i] = 1'b1;
				tcv_pkg::OM_TOGGLE:
					if (eq_ev) state_next.outq[i] = ~state_reg.outq[i];
				tcv_pkg::OM_RESET:
					if (eq_ev) state_next.outq[i] = 1'b0;
				tcv_pkg::OM_TGL_RST: begin
					if (eq_ev) state_next.outq[i] = ~state_reg.outq[i];
					if (per_ev) state_next.outq[i] = 1'b0;
				end
				tcv_pkg::OM_SET_RST: begin
					if (eq_ev) state_next.outq[i] = 1'b1;
					if (per_ev) state_next.outq[i] = 1'b0;
				end
				tcv_pkg::OM_TGL_SET: begin
					if (eq_ev) state_next.outq[i] = ~state_reg.outq[i];
					if (per_ev) state_next.outq[i] = 1'b1;
				end
				tcv_pkg::OM_RST_SET: begin
					if (eq_ev) state_next.outq[i] = 1'b0;
					if (per_ev) state_next.outq[i] = 1'b1;
				end
			endcase
		end

		if (vec_access && vif.top[tcv_pkg::NSH-1])
			state_next.ovf_flag = 1'b0;
		if (counter_wrap)
			state_next.ovf_flag = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= '0;
			for (int i = 0; i < tcv_pkg::NCH; i++) begin
				state_reg.ctl[i] <= tcv_pkg::CTL_RESET;
			end
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : tcv_channel_ctrl
`default_nettype wire

// ### tcv_count_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcv_count_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic        clear,
	input  wire logic [15:0] top,
	output logic      [15:0] value,
	output logic             step,
	output logic             wrap
);
	// Holds its value while stopped so a pass can be split in two
	always_ff @(posedge clock) begin
		if (!rst_n || clear) begin
			value <= 16'h0000;
			step  <= 1'b0;
			wrap  <= 1'b0;
		end else begin
			step <= run;
			wrap <= run && value == top;
			if (run) begin
				value <= (value == top) ? 16'h0000 : value + 16'h0001;
			end
		end
	end
endmodule : tcv_count_model
`default_nettype wire

// ### tcv_chan_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tcv_chk (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire logic [15:0]             bus_addr,
	input wire logic                    bus_wr,
	input wire logic                    bus_rd,
	input wire logic [15:0]             bus_rdata,
	input wire logic                    count_step,
	input wire logic                    counter_wrap,
	input wire logic                    ch0_irq_accept,
	input wire logic [tcv_pkg::NCH-1:0] out_pin,
	input wire logic [15:0]             period_latch,
	input wire logic                    irq_ch0,
	input wire logic                    irq_shared
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_RST: assert property (disable iff (1'b0) !rst_n |=> out_pin == '0 && !irq_ch0
		&& !irq_shared && bus_rdata == 16'h0000) else $error("reset state wrong");
	AST_OUT_STILL: assert property (!bus_wr ##1 !count_step |=> $stable(out_pin))
		else $error("output moved without event");
	AST_RD_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data moved");
	AST_VEC_CODE: assert property (bus_rd && bus_addr == tcv_pkg::ADDR_VECTOR |=>
		!bus_rdata[0] && bus_rdata <= tcv_pkg::VEC_OVERFLOW) else $error("bad vector code");
	AST_CH0_FALL: assert property ($fell(irq_ch0) |-> $past(ch0_irq_accept) || $past(bus_wr))
		else $error("ch0 request dropped alone");
	AST_SH_FALL: assert property ($fell(irq_shared) |-> $past(bus_rd) || $past(bus_wr))
		else $error("shared request dropped alone");
	AST_LATCH: assert property ($changed(period_latch) |-> $past(bus_wr) || $past(count_step))
		else $error("latch loaded without cause");
	AST_WRAP: assert property (counter_wrap |=> irq_shared)
		else $error("overflow not requested");
endmodule : tcv_chk
bind tcv_channel_ctrl tcv_chk i_chk (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .count_step(count_step),
	.counter_wrap(counter_wrap), .ch0_irq_accept(ch0_irq_accept), .out_pin(out_pin),
	.period_latch(period_latch), .irq_ch0(irq_ch0), .irq_shared(irq_shared));
`default_nettype wire

// ### timer_channel_ctrl_and_vector_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module timer_channel_ctrl_and_vector_test;
	logic                    clock = 0;
	logic                    rst_n = 0;
	logic [15:0]             bus_addr = 0;
	logic [15:0]             bus_wdata = 0;
	logic                    bus_wr = 0;
	logic                    bus_rd = 0;
	logic                    accept = 0;
	logic                    run = 0;
	logic                    clear = 0;
	logic                    updown = 0;
	logic [tcv_pkg::NCH-1:0] pin_a = '0;
	logic [tcv_pkg::NCH-1:0] pin_b = '0;
	logic [15:0]             bus_rdata, cval, period_latch;
	logic                    step, wrap, irq_ch0, irq_shared;
	logic [tcv_pkg::NCH-1:0] out_pin;
	int                      miscompares = 0;
	int                      checked = 0;
	int                      cycles = 0;
	// Output after the channel event and after the period event, by mode
	logic [7:0]              exp5 [2] = '{8'h5E, 8'h0B};
	logic [7:0]              exp9 [2] = '{8'hD2, 8'hC3};
	always #25 clock = ~clock;
	tcv_count_model i_cnt (.clock(clock), .rst_n(rst_n), .run(run), .clear(clear),
		.top(16'h0009), .value(cval), .step(step), .wrap(wrap));
	tcv_channel_ctrl i_dut (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.counter_value(cval), .count_step(step), .count_updown(updown), .counter_wrap(wrap),
		.ch0_irq_accept(accept), .snapshot_input_a(pin_a), .snapshot_input_b(pin_b),
		.out_pin(out_pin), .period_latch(period_latch), .irq_ch0(irq_ch0),
		.irq_shared(irq_shared));
	task automatic wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clock);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1;
		@(negedge clock);
		bus_wr = 0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(negedge clock);
		bus_addr = a;
		bus_rd = 1;
		@(negedge clock);
		bus_rd = 0;
		`CHK(bus_rdata, e)
	endtask : rd
	task automatic go(input int n);
		@(negedge clock);
		run = 1;
		repeat (n) @(negedge clock);
		run = 0;
		repeat (2) @(negedge clock);
	endtask : go
	task automatic clr;
		@(negedge clock);
		clear = 1;
		@(negedge clock);
		clear = 0;
	endtask : clr
	task automatic t_reset;
		rd(16'h0184, 16'h0000);
		rd(16'h011E, 16'h0000);
		rd(16'h0100, 16'h0000);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_modes;
		wr(16'h0192, 16'h0009);
		wr(16'h0194, 16'h0005);
		`CHK(period_latch, 16'h0009)
		for (int m = 0; m < 8; m++) for (int s = 0; s < 2; s++) begin
			clr();
			wr(16'h0184, 16'(s << 2));
			repeat (2) @(negedge clock);
			`CHK(out_pin[1], 1'(s))
			wr(16'h0184, 16'((m << 5) | (s << 2)));
			go(5);
			`CHK(out_pin[1], exp5[s][m])
			go(4);
			`CHK(out_pin[1], exp9[s][m])
		end
		$display("t_modes done");
	endtask : t_modes
	task automatic t_vector;
		wr(16'h0184, 16'h0000);
		wr(16'h0182, 16'h0010);
		wr(16'h0186, 16'h0011);
		wr(16'h0188, 16'h0011);
		`CHK(irq_shared, 1'b1)
		rd(16'h011E, 16'h0004);
		`CHK(irq_shared, 1'b1)
		rd(16'h011E, 16'h0006);
		wr(16'h0186, 16'h0011);
		wr(16'h011E, 16'h0000);
		rd(16'h011E, 16'h0000);
		// A full pass hits every latch and wraps, so all shared flags set
		clr();
		go(10);
		`CHK(irq_ch0, 1'b1)
		for (int k = 1; k < 8; k++) rd(16'h011E, 16'(2 * k));
		rd(16'h011E, 16'h0000);
		`CHK(irq_shared, 1'b0)
		@(negedge clock);
		accept = 1;
		@(negedge clock);
		accept = 0;
		`CHK(irq_ch0, 1'b0)
		$display("t_vector done");
	endtask : t_vector
	task automatic t_snap;
		clr();
		go(3);
		wr(16'h018A, 16'h6100);
		wr(16'h018A, 16'h7100);
		repeat (6) @(negedge clock);
		rd(16'h019A, 16'h0003);
		rd(16'h018A, 16'h7109);
		for (int i = 0; i < 2; i++) begin
			wr(16'h018A, 16'h6100);
			wr(16'h018A, 16'h7100);
			repeat (6) @(negedge clock);
		end
		rd(16'h018A, 16'h710B);
		rd(16'h019A, 16'h0003);
		rd(16'h018A, 16'h710B);
		go(2);
		wr(16'h018A, 16'hB900);
		wr(16'h018A, 16'hA900);
		repeat (6) @(negedge clock);
		rd(16'h019A, 16'h0005);
		rd(16'h018A, 16'hA901);
		$display("t_snap done");
	endtask : t_snap
	// Channel 0 latch is the only one visible, so load selects are proven there
	task automatic t_load;
		wr(16'h0182, 16'h0200);
		wr(16'h0192, 16'h0007);
		go(2);
		`CHK(period_latch, 16'h0009)
		go(4);
		`CHK(period_latch, 16'h0007)
		wr(16'h0182, 16'h0400);
		wr(16'h0192, 16'h0003);
		go(6);
		`CHK(period_latch, 16'h0007)
		updown = 1;
		clr();
		go(7);
		`CHK(period_latch, 16'h0003)
		updown = 0;
		wr(16'h0192, 16'h0006);
		go(3);
		`CHK(period_latch, 16'h0006)
		wr(16'h0182, 16'h0600);
		wr(16'h0192, 16'h0002);
		go(5);
		`CHK(period_latch, 16'h0006)
		go(1);
		`CHK(period_latch, 16'h0002)
		$display("t_load done");
	endtask : t_load
	task automatic t_pins;
		wr(16'h018C, 16'hC100);
		pin_b[5] = 1'b1;
		repeat (5) @(negedge clock);
		rd(16'h018C, 16'hC100);
		pin_a[5] = 1'b1;
		repeat (5) @(negedge clock);
		rd(16'h019C, 16'h0006);
		rd(16'h018C, 16'hC109);
		go(1);
		pin_a[5] = 1'b0;
		repeat (5) @(negedge clock);
		rd(16'h019C, 16'h0007);
		rd(16'h018C, 16'hC101);
		go(1);
		wr(16'h018C, 16'hD100);
		repeat (3) @(negedge clock);
		rd(16'h019C, 16'h0008);
		rd(16'h018C, 16'hD109);
		$display("t_pins done");
	endtask : t_pins
	initial begin
		repeat (10) @(negedge clock);
		rst_n = 1;
		t_reset();
		t_modes();
		t_vector();
		t_snap();
		t_load();
		t_pins();
		wrap_up();
	end
endmodule : timer_channel_ctrl_and_vector_test
`default_nettype wire
